// ---- verilog/cpic_ctrl.sv ----
/*
  Eight-level priority interrupt controller with cascade support,
  register access over APB and a two-pulse acknowledge from the CPU.
  Assumes request, acknowledge, cascade and role pins are asynchronous
  and the APB master shares sys_clk.
*/
// Summary of operation
// (R1) One master, up to eight slaves, 64 levels
// (R2) Unbuffered cascade: role from role-select pin
// (R3) Buffered cascade: role from control bit two
// (R4) Master names serviced slave on cascade lines
// (R5) Acknowledge sets in-service; auto close clears it
// (R6) Non-specific done clears highest in-service level; under special mask the code clears none
// (R7) Specific done clears the named level
// (R8) After init: nested, input zero highest
// (R9) Latch requests; acknowledge serves highest pending
// (R10) Nested: only strictly higher levels interrupt
// (R11) Special mask: any unmasked level may interrupt
// (R12) Special nesting forwards same-slave higher requests
// (R13) Software sets special nesting on master only
// (R14) Software closes slave first, then master
// (R15) Software avoids auto close with special nesting
// (R16) Software uses specific done under special mask
// (R17) Priority command makes named level lowest
// (R18) Rotation with specific done or alone
// (R19) Slave request output feeds master request input
// (R20) Auto close at trailing edge of last pulse
// (R21) Vector: level in bits 0-2, base above
// (R22) Buffered: role pin enables external data buffers
// (R23) Auto rotation: finished level becomes lowest
// (R24) Only the named slave drives the data bus
`timescale 1ns/10ps

module cpic_ctrl
  import cpic_pkg::*;
#(
  parameter int LEVELS = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LEVELS-1:0] requestInputs,
  input wire logic acknowledgePulse,
  output logic intRequest,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [2:0] cascadeIdIn,
  output logic [2:0] cascadeIdOut,
  output logic cascadeIdOe,
  input wire logic roleSelectIn,
  output logic roleSelectBufEnN,
  output logic roleSelectOe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] vecBase;
    logic [7:0] cascadeMap;
    logic [7:0] mask;
    logic [7:0] requestFlags;
    logic [7:0] inServiceFlags;
    logic [2:0] lowest;
    logic [7:0] reqSync1;
    logic [7:0] reqSync2;
    logic [7:0] reqPrev;
    logic ackSync1;
    logic ackSync2;
    logic ackPrev;
    logic [2:0] casSync1;
    logic [2:0] casSync2;
    logic roleSync1;
    logic roleSync2;
    cpic_phase_t phase;
    logic [2:0] ackLevel;
    logic ackValid;
    logic intRequest;
    logic [7:0] dataOut;
    logic dataOe;
    logic [2:0] casOut;
    logic casOe;
    logic bufEnN;
    logic bufOe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpic_state_t;

  cpic_state_t state_reg;
  cpic_state_t state_next;

  // Highest-priority set bit; 8 when none. Priority runs upward from lowest+1.
  function automatic logic [3:0] pickTop(input logic [7:0] vec, input logic [2:0] lowest);
    logic [2:0] idx;
    pickTop = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      idx = lowest + 3'(k) + 3'h1;
      if (vec[idx]) begin
        pickTop = {1'b0, idx};
      end
    end
  endfunction

  // 0 is the highest rank, 8 means no level
  function automatic logic [3:0] rankOf(input logic [3:0] level, input logic [2:0] lowest);
    rankOf = level[3] ? 4'h8 : {1'b0, 3'(level[2:0] - lowest - 3'h1)};
  endfunction

  // ----------------------------------------------------------------
  // Decoded modes
  // ----------------------------------------------------------------
  logic cascadeMode;
  logic isMaster;
  logic isSlave;
  logic [3:0] topPending;
  logic [3:0] topService;
  logic [3:0] pendRank;
  logic [3:0] servRank;
  logic wantInt;
  logic apbAccess;
  logic apbWrite;
  logic [7:0] wdata;
  logic addrOk;

  always_comb begin
    cascadeMode = state_reg.ctrl[CPIC_CTRL_CASCADE];
    // Buffered mode frees the pin for the buffer enable, so role comes from software
    isMaster = !cascadeMode || (state_reg.ctrl[CPIC_CTRL_BUFFERED] ? state_reg.ctrl[CPIC_CTRL_MASTER] // R3
                                                                   : state_reg.roleSync2); // R2
    isSlave = !isMaster;
    topPending = pickTop(state_reg.requestFlags & ~state_reg.mask, state_reg.lowest); // R9
    // Special mask lets in-service levels stop blocking anyone
    topService = pickTop(state_reg.inServiceFlags & ~(state_reg.ctrl[CPIC_CTRL_SPECMASK] ? 8'hFF : 8'h00),
                         state_reg.lowest); // R11
    pendRank = rankOf(topPending, state_reg.lowest);
    servRank = rankOf(topService, state_reg.lowest);
    wantInt = !topPending[3] && ((pendRank < servRank) // R10
              || (pendRank == servRank && isMaster && cascadeMode
                  && state_reg.ctrl[CPIC_CTRL_SPECNEST] && state_reg.cascadeMap[topPending[2:0]])); // R12
    apbAccess = psel && penable && state_reg.pready;
    apbWrite = apbAccess && pwrite;
    wdata = pwdata[7:0];
    addrOk = (paddr[1:0] == 2'h0) && (paddr <= CPIC_OFS_STATUS);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] reqRise;
  logic [7:0] irrClr;
  logic [7:0] isrSet;
  logic [7:0] isrClr;
  logic ackRise;
  logic ackFall;
  logic cascadedLevel;

  always_comb begin
    state_next = state_reg;
    reqRise = 8'h00;
    irrClr = 8'h00;
    isrSet = 8'h00;
    isrClr = 8'h00;
    cascadedLevel = 1'b0;

    state_next.reqSync1 = requestInputs;
    state_next.reqSync2 = state_reg.reqSync1;
    state_next.reqPrev = state_reg.reqSync2;
    state_next.ackSync1 = acknowledgePulse;
    state_next.ackSync2 = state_reg.ackSync1;
    state_next.ackPrev = state_reg.ackSync2;
    state_next.casSync1 = cascadeIdIn;
    state_next.casSync2 = state_reg.casSync1;
    state_next.roleSync1 = roleSelectIn;
    state_next.roleSync2 = state_reg.roleSync1;
    reqRise = state_reg.reqSync2 & ~state_reg.reqPrev;
    ackRise = state_reg.ackSync2 && !state_reg.ackPrev;
    ackFall = !state_reg.ackSync2 && state_reg.ackPrev;

    // Software commands
    if (apbWrite && addrOk) begin
      unique case (paddr)
        CPIC_OFS_CTRL: begin
          state_next.ctrl = wdata;
          // Writing control restarts the controller in fully nested order
          state_next.requestFlags = CPIC_RST_FLAGS; // R8
          state_next.inServiceFlags = CPIC_RST_FLAGS;
          state_next.mask = CPIC_RST_FLAGS;
          state_next.lowest = CPIC_RST_LOWEST; // R8
          state_next.phase = CPIC_IDLE;
        end
        CPIC_OFS_VECTOR: state_next.vecBase = wdata;
        CPIC_OFS_CASCADE: state_next.cascadeMap = wdata;
        CPIC_OFS_MASK: state_next.mask = wdata;
        CPIC_OFS_COMMAND: begin
          if (wdata[CPIC_CMD_DONE] && wdata[CPIC_CMD_SPECIFIC]) begin
            isrClr[wdata[2:0]] = 1'b1; // R7
          end else if (wdata[CPIC_CMD_DONE] && !topService[3]) begin
            isrClr[topService[2:0]] = 1'b1; // R6
          end
          if (wdata[CPIC_CMD_ROTATE] && wdata[CPIC_CMD_SPECIFIC]) begin
            state_next.lowest = wdata[2:0]; // R17 R18
          end else if (wdata[CPIC_CMD_ROTATE] && wdata[CPIC_CMD_DONE] && !topService[3]) begin
            state_next.lowest = topService[2:0]; // R23
          end
        end
        default: begin
        end
      endcase
    end

    // Acknowledge sequence
    unique case (state_reg.phase)
      CPIC_IDLE: begin
        if (ackRise) begin
          state_next.phase = CPIC_FIRST;
          state_next.ackValid = 1'b0;
          if (isMaster && !topPending[3]) begin
            state_next.ackLevel = topPending[2:0];
            state_next.ackValid = 1'b1;
            isrSet[topPending[2:0]] = 1'b1; // R5 R9
            irrClr[topPending[2:0]] = 1'b1;
            if (cascadeMode && state_reg.cascadeMap[topPending[2:0]]) begin
              state_next.casOut = topPending[2:0]; // R4 R24
              state_next.casOe = 1'b1;
            end
          end else if (isMaster) begin
            // Spurious acknowledge answers with the lowest level, nothing set
            state_next.ackLevel = state_reg.lowest;
          end
        end
      end
      CPIC_FIRST: begin
        if (ackRise) begin
          state_next.phase = CPIC_SECOND;
          cascadedLevel = cascadeMode && state_reg.ackValid && state_reg.cascadeMap[state_reg.ackLevel];
          if (isSlave) begin
            // A slave joins only when the master names it on the cascade lines
            if (state_reg.casSync2 == state_reg.cascadeMap[2:0]) begin // R1 R24
              state_next.ackLevel = topPending[3] ? state_reg.lowest : topPending[2:0];
              state_next.ackValid = !topPending[3];
              if (!topPending[3]) begin
                isrSet[topPending[2:0]] = 1'b1; // R5
                irrClr[topPending[2:0]] = 1'b1;
              end
              state_next.dataOut = {state_reg.vecBase[7:CPIC_VEC_BASE_LSB],
                                    topPending[3] ? state_reg.lowest : topPending[2:0]}; // R21
              state_next.dataOe = 1'b1;
            end
          end else if (!cascadedLevel) begin
            state_next.dataOut = {state_reg.vecBase[7:CPIC_VEC_BASE_LSB], state_reg.ackLevel}; // R21
            state_next.dataOe = 1'b1;
          end
        end
      end
      CPIC_SECOND: begin
        if (ackFall) begin
          state_next.phase = CPIC_IDLE;
          state_next.dataOe = 1'b0;
          state_next.casOe = 1'b0;
          if (state_reg.ctrl[CPIC_CTRL_AUTOCLOSE] && state_reg.ackValid) begin
            isrClr[state_reg.ackLevel] = 1'b1; // R5 R20
            if (state_reg.ctrl[CPIC_CTRL_AUTOROT]) begin
              state_next.lowest = state_reg.ackLevel; // R23
            end
          end
        end
      end
      default: state_next.phase = CPIC_IDLE;
    endcase

    // Flags: a new event wins over a clear in the same cycle, except level-mode requests, where the acknowledge clear wins
    if (!(apbWrite && addrOk && paddr == CPIC_OFS_CTRL)) begin
      if (state_reg.ctrl[CPIC_CTRL_LEVEL]) begin
        state_next.requestFlags = state_reg.reqSync2 & ~irrClr;
      end else begin
        state_next.requestFlags = (state_reg.requestFlags & ~irrClr) | reqRise; // R9
      end
      state_next.inServiceFlags = (state_reg.inServiceFlags & ~isrClr) | isrSet;
    end

    // Slave request reaches master as an ordinary input
    state_next.intRequest = wantInt; // R19
    // Active-low buffer enable follows the data drivers
    state_next.bufOe = state_reg.ctrl[CPIC_CTRL_BUFFERED]; // R22
    state_next.bufEnN = !state_next.dataOe; // R22

    // APB: one wait state, read data captured before the completing edge
    state_next.pready = psel && penable && !state_reg.pready;
    state_next.pslverr = psel && penable && !state_reg.pready && !addrOk;
    state_next.prdata = 32'h0000_0000;
    if (psel && penable && !state_reg.pready && !pwrite) begin
      unique case (paddr)
        CPIC_OFS_CTRL: state_next.prdata = {24'h00_0000, state_reg.ctrl};
        CPIC_OFS_VECTOR: state_next.prdata = {24'h00_0000, state_reg.vecBase};
        CPIC_OFS_CASCADE: state_next.prdata = {24'h00_0000, state_reg.cascadeMap};
        CPIC_OFS_MASK: state_next.prdata = {24'h00_0000, state_reg.mask};
        CPIC_OFS_REQUEST: state_next.prdata = {24'h00_0000, state_reg.requestFlags};
        CPIC_OFS_INSERVICE: state_next.prdata = {24'h00_0000, state_reg.inServiceFlags};
        CPIC_OFS_STATUS: state_next.prdata = {24'h00_0000, state_reg.phase, state_reg.intRequest,
                                              isMaster, state_reg.lowest};
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.ctrl <= CPIC_RST_CTRL;
      state_reg.lowest <= CPIC_RST_LOWEST; // R8
      state_reg.phase <= CPIC_IDLE;
      state_reg.bufEnN <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign intRequest = state_reg.intRequest;
  assign dataOut = state_reg.dataOut;
  assign dataOe = state_reg.dataOe;
  assign cascadeIdOut = state_reg.casOut;
  assign cascadeIdOe = state_reg.casOe;
  assign roleSelectBufEnN = state_reg.bufEnN;
  assign roleSelectOe = state_reg.bufOe;

endmodule

// ---- verilog/cpic_pkg.sv ----
/*
  Constants, register map and types for the cascadable priority
  interrupt controller.
  Assumes a 32-bit APB master and one 10 MHz system clock.
*/
package cpic_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CPIC_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPIC_OFS_VECTOR = 8'h04;
  localparam logic [7:0] CPIC_OFS_CASCADE = 8'h08;
  localparam logic [7:0] CPIC_OFS_MASK = 8'h0C;
  localparam logic [7:0] CPIC_OFS_COMMAND = 8'h10;
  localparam logic [7:0] CPIC_OFS_REQUEST = 8'h14;
  localparam logic [7:0] CPIC_OFS_INSERVICE = 8'h18;
  localparam logic [7:0] CPIC_OFS_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CPIC_CTRL_CASCADE = 0;
  localparam int CPIC_CTRL_BUFFERED = 1;
  localparam int CPIC_CTRL_MASTER = 2;
  localparam int CPIC_CTRL_AUTOCLOSE = 3;
  localparam int CPIC_CTRL_SPECNEST = 4;
  localparam int CPIC_CTRL_SPECMASK = 5;
  localparam int CPIC_CTRL_AUTOROT = 6;
  localparam int CPIC_CTRL_LEVEL = 7;

  // ----------------------------------------------------------------
  // Command register fields and vector layout
  // ----------------------------------------------------------------
  localparam int CPIC_CMD_SPECIFIC = 5;
  localparam int CPIC_CMD_DONE = 6;
  localparam int CPIC_CMD_ROTATE = 7;
  localparam int CPIC_VEC_BASE_LSB = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CPIC_RST_CTRL = 8'h00;
  localparam logic [2:0] CPIC_RST_LOWEST = 3'h7;
  localparam logic [7:0] CPIC_RST_FLAGS = 8'h00;

  typedef enum logic [2:0] {
    CPIC_IDLE = 3'b001,
    CPIC_FIRST = 3'b010,
    CPIC_SECOND = 3'b100
  } cpic_phase_t;

endpackage

// ---- tb/cpic_ctrl_chk.sv ----
/*
  Concurrent checks on the controller's APB and vector pins.
  Assumes it is bound to cpic_ctrl and sees only its ports.
*/
`timescale 1ns/10ps

module cpic_ctrl_chk #(
  parameter int LEVELS = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic roleSelectBufEnN
);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_err_unmapped;
    psel && penable && !pready && (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on bad address");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside completion");
  property p_rdata_upper;
    prdata[31:8] == 24'h0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
  property p_buf_enable;
    roleSelectBufEnN != dataOe;
  endproperty
  a_buf_enable: assert property (p_buf_enable) else $error("buffer enable not tied to drive");
  property p_vec_stable;
    dataOe && $past(dataOe) |-> $stable(dataOut);
  endproperty
  a_vec_stable: assert property (p_vec_stable) else $error("vector changed while driven");
endmodule

bind cpic_ctrl cpic_ctrl_chk #(.LEVELS(LEVELS)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dataOut(dataOut), .dataOe(dataOe), .roleSelectBufEnN(roleSelectBufEnN));

// ---- tb/cpic_host_model.sv ----
/*
  Host CPU model: gives two-pulse acknowledges and records what the
  controller puts on the vector and cascade lines meanwhile.
  Assumes the bench raises go for one cycle and waits on busy.
*/
`timescale 1ns/10ps

module cpic_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic dataOe,
  input wire logic [7:0] dataOut,
  input wire logic cascadeIdOe,
  input wire logic [2:0] cascadeIdOut,
  output logic acknowledgePulse,
  output logic busy,
  output logic sawData,
  output logic [7:0] vecSeen,
  output logic sawCas,
  output logic [2:0] casSeen
);
  // ------------------------------------------------
  // Acknowledge sequence
  // ------------------------------------------------
  initial begin
    acknowledgePulse = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'b1;
        // Four clocks each way, so the synchronisers see every edge
        repeat (2) begin
          acknowledgePulse <= 1'b1;
          repeat (4) @(posedge sys_clk);
          acknowledgePulse <= 1'b0;
          repeat (4) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
        busy <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (go) begin
      sawData <= 1'b0;
      sawCas <= 1'b0;
    end else begin
      if (dataOe) begin
        sawData <= 1'b1;
        vecSeen <= dataOut;
      end
      if (cascadeIdOe) begin
        sawCas <= 1'b1;
        casSeen <= cascadeIdOut;
      end
    end
  end
endmodule

// ---- tb/cascadable_priority_interrupt_ctrl_test.sv ----
/*
  Self-checking bench for the interrupt controller: APB tasks, a host
  model for acknowledges, and sequences of calls with expected values.
  Assumes one 10 MHz clock and the checker bound to the design.
*/
`timescale 1ns/10ps

module cascadable_priority_interrupt_ctrl_test;
  import cpic_pkg::*;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, acknowledgePulse, intRequest;
  logic dataOe, cascadeIdOe, roleSelectIn, roleSelectBufEnN, roleSelectOe, go, busy, sawData, sawCas, errv;
  logic [7:0] paddr, requestInputs, dataOut, vecSeen;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] cascadeIdIn, cascadeIdOut, casSeen;
  int n_mismatch, compares, cycles;

  cpic_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .requestInputs(requestInputs), .acknowledgePulse(acknowledgePulse), .intRequest(intRequest),
    .dataOut(dataOut), .dataOe(dataOe), .cascadeIdIn(cascadeIdIn), .cascadeIdOut(cascadeIdOut),
    .cascadeIdOe(cascadeIdOe), .roleSelectIn(roleSelectIn), .roleSelectBufEnN(roleSelectBufEnN),
    .roleSelectOe(roleSelectOe));
  cpic_host_model host (.sys_clk(sys_clk), .go(go), .dataOe(dataOe), .dataOut(dataOut),
    .cascadeIdOe(cascadeIdOe), .cascadeIdOut(cascadeIdOut), .acknowledgePulse(acknowledgePulse),
    .busy(busy), .sawData(sawData), .vecSeen(vecSeen), .sawCas(sawCas), .casSeen(casSeen));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task cmd(input logic [31:0] v);
    apb(1'b1, CPIC_OFS_COMMAND, v);
  endtask
  task in_service_flags(input logic [31:0] exp);
    rdchk(CPIC_OFS_INSERVICE, exp);
  endtask
  task ack;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy !== 1'b0) @(posedge sys_clk);
  endtask
  // Six clocks cover the edge detector and the request update
  task reqs(input logic [7:0] v);
    requestInputs <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  task finish_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Clock, timeout and sequence
  // ------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    {reset_n, psel, penable, pwrite, go, roleSelectIn} = 6'h0;
    {paddr, requestInputs, pwdata, cascadeIdIn} = 51'h0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(CPIC_OFS_CTRL, 32'h0);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'hE7, 32'h27);
    apb(1'b0, 8'h20, 32'h0);
    chk1(errv, 1'b1);
    apb(1'b0, 8'h02, 32'h0);
    chk1(errv, 1'b1);
    apb(1'b1, CPIC_OFS_VECTOR, 32'h18);
    chk1(errv, 1'b0);
    reqs(8'h0A);
    rdchk(CPIC_OFS_REQUEST, 32'h0A);
    chk1(intRequest, 1'b1);
    ack;
    chk(vecSeen, 32'h19);
    in_service_flags(32'h02);
    rdchk(CPIC_OFS_REQUEST, 32'h08);
    chk1(intRequest, 1'b0);
    reqs(8'h0B);
    chk1(intRequest, 1'b1);
    ack;
    chk(vecSeen, 32'h18);
    in_service_flags(32'h03);
    cmd(32'h40);
    in_service_flags(32'h02);
    cmd(32'h61);
    in_service_flags(32'h00);
    ack;
    chk(vecSeen, 32'h1B);
    cmd(32'hA3);
    in_service_flags(32'h08);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'h07, 32'h03);
    cmd(32'hE3);
    in_service_flags(32'h00);
    reqs(8'h00);
    reqs(8'h24);
    ack;
    chk(vecSeen, 32'h1D);
    cmd(32'h65);
    apb(1'b1, CPIC_OFS_CTRL, 32'h08);
    reqs(8'h00);
    reqs(8'h40);
    ack;
    chk(vecSeen & 32'h07, 32'h06);
    in_service_flags(32'h00);
    apb(1'b1, CPIC_OFS_CTRL, 32'h20);
    reqs(8'h00);
    reqs(8'h04);
    ack;
    in_service_flags(32'h04);
    apb(1'b1, CPIC_OFS_MASK, 32'h84);
    reqs(8'h84);
    chk1(intRequest, 1'b0);
    reqs(8'hC4);
    chk1(intRequest, 1'b1);
    ack;
    chk(vecSeen & 32'h07, 32'h06);
    cmd(32'h66);
    cmd(32'h62);
    in_service_flags(32'h00);
    roleSelectIn <= 1'b1;
    apb(1'b1, CPIC_OFS_CTRL, 32'h11);
    apb(1'b1, CPIC_OFS_CASCADE, 32'h10);
    reqs(8'h00);
    reqs(8'h10);
    ack;
    chk1(sawCas, 1'b1);
    chk({29'h0, casSeen}, 32'h04);
    chk1(sawData, 1'b0);
    reqs(8'h00);
    reqs(8'h10);
    chk1(intRequest, 1'b1);
    cmd(32'h40);
    in_service_flags(32'h00);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'h08, 32'h08);
    apb(1'b1, CPIC_OFS_CTRL, 32'h03);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'h08, 32'h00);
    chk1(roleSelectOe, 1'b1);
    apb(1'b1, CPIC_OFS_CTRL, 32'h07);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'h08, 32'h08);
    roleSelectIn <= 1'b0;
    apb(1'b1, CPIC_OFS_CTRL, 32'h01);
    apb(1'b0, CPIC_OFS_STATUS, 32'h0);
    chk(rdv & 32'h08, 32'h00);
    apb(1'b1, CPIC_OFS_CASCADE, 32'h05);
    reqs(8'h00);
    reqs(8'h04);
    chk1(intRequest, 1'b1);
    cascadeIdIn <= 3'h3;
    ack;
    chk1(sawData, 1'b0);
    cascadeIdIn <= 3'h5;
    ack;
    chk1(sawData, 1'b1);
    chk(vecSeen & 32'h07, 32'h02);
    finish_test;
  end
endmodule
